// ===== verilog/pac_pkg.sv
package pac_pkg;
    localparam int            ADDR_W          = 10;
    localparam int            DATA_W          = 8;
    localparam int            SEL_W           = 6;
    localparam int            NUM_SRC         = 64;
    localparam logic [9:0]    STAT_CTRL_ADDR  = 10'h017;
    localparam logic [9:0]    AUX_CTRL_ADDR   = 10'h01D;
    localparam logic [9:0]    PLL_READ_ADDR   = 10'h01F;
    localparam logic [7:0]    AUX_RESET       = 8'h80;
    localparam logic [7:0]    STAT_RESET      = 8'h00;
    localparam logic [7:0]    READ_RESET      = 8'h00;
    localparam logic [7:0]    AUX_USED_MASK   = 8'hFB;
    localparam logic [7:0]    STAT_USED_MASK  = 8'hFC;
    localparam int            EEPROM_STAT_BIT = 7;
    localparam int            XTAL_EN_BIT     = 6;
    localparam int            DOUBLER_BIT     = 5;
    localparam int            FREEZE_BIT      = 4;
    localparam int            LD_COMP_BIT     = 3;
    localparam int            EXT_HOLD_BIT    = 1;
    localparam int            HOLD_EN_BIT     = 0;
    localparam int            SEL_LSB         = 2;
endpackage : pac_pkg

// ===== verilog/pac_sync.sv
`timescale 1ns/10ps
module pac_sync (
    input  wire logic i_clk,
    input  wire logic i_reset,
    input  wire logic i_async,
    output logic      o_sync
);
    logic stage1_reg;
    logic stage2_reg;
    logic stage1_next;
    logic stage2_next;

    // First stage is read only by the second
    always_comb begin
        stage1_next = i_async;
        stage2_next = stage1_reg;
    end

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            stage1_reg <= 1'b0;
            stage2_reg <= 1'b0;
        end else begin
            stage1_reg <= stage1_next;
            stage2_reg <= stage2_next;
        end
    end

    assign o_sync = stage2_reg;
endmodule : pac_sync

// ===== verilog/pac_aux_ctrl.sv
`timescale 1ns/10ps
module pac_aux_ctrl (
    input  wire logic                          i_clk,
    input  wire logic                          i_reset,
    input  wire logic                          i_wr_en,
    input  wire logic [pac_pkg::ADDR_W-1:0]    i_addr,
    input  wire logic [pac_pkg::DATA_W-1:0]    i_wr_data,
    input  wire logic                          i_rd_en,
    output logic      [pac_pkg::DATA_W-1:0]    o_rd_data,
    input  wire logic [pac_pkg::NUM_SRC-1:0]   i_status_src,
    input  wire logic                          i_eeprom_status,
    input  wire logic [pac_pkg::DATA_W-1:0]    i_pll_status,
    input  wire logic                          i_lock_detect_pin_cmp,
    output logic                               o_status_pin,
    output logic                               o_crystal_maintaining_amp_en,
    output logic                               o_doubler_en,
    output logic                               o_lock_detect_pin_cmp_en,
    output logic                               o_holdover_lock_ind,
    output logic                               o_ld_monitor,
    output logic                               o_auto_holdover
);
    import pac_pkg::*;

    logic [DATA_W-1:0] aux_reg;
    logic [DATA_W-1:0] aux_next;
    logic [DATA_W-1:0] stat_reg;
    logic [DATA_W-1:0] stat_next;
    logic [DATA_W-1:0] pll_read_reg;
    logic [DATA_W-1:0] pll_read_next;
    logic [DATA_W-1:0] rd_data_reg;
    logic [DATA_W-1:0] rd_data_next;
    logic              status_reg;
    logic              status_next;
    logic              hold_ind_reg;
    logic              hold_ind_next;
    logic              monitor_reg;
    logic              monitor_next;
    logic              auto_hold_reg;
    logic              auto_hold_next;
    logic              cmp_sync;
    logic [SEL_W-1:0]  sel;
    logic              auto_hold;

    // Comparator output is analog, so it is synchronised first
    pac_sync u_cmp_sync (
        .i_clk   (i_clk),
        .i_reset (i_reset),
        .i_async (i_lock_detect_pin_cmp),
        .o_sync  (cmp_sync)
    );

    function automatic logic hit(input logic [ADDR_W-1:0] a,
                                 input logic [ADDR_W-1:0] b);
        hit = (a == b);
    endfunction : hit

    assign sel       = stat_reg[SEL_LSB +: SEL_W];
    // External holdover bit hands control to the sync pin
    assign auto_hold = aux_reg[HOLD_EN_BIT] & ~aux_reg[EXT_HOLD_BIT];

    always_comb begin
        aux_next      = aux_reg;
        stat_next     = stat_reg;
        pll_read_next = pll_read_reg;
        rd_data_next  = rd_data_reg;
        if (i_wr_en && hit(i_addr, AUX_CTRL_ADDR)) begin
            aux_next = i_wr_data & AUX_USED_MASK;
        end
        if (i_wr_en && hit(i_addr, STAT_CTRL_ADDR)) begin
            stat_next = i_wr_data & STAT_USED_MASK;
        end
        if (!aux_reg[FREEZE_BIT]) begin
            pll_read_next = i_pll_status;
        end
        if (i_rd_en) begin
            if (hit(i_addr, AUX_CTRL_ADDR)) begin
                rd_data_next = aux_reg;
            end else if (hit(i_addr, STAT_CTRL_ADDR)) begin
                rd_data_next = stat_reg;
            end else if (hit(i_addr, PLL_READ_ADDR)) begin
                rd_data_next = pll_read_reg;
            end else begin
                rd_data_next = '0;
            end
        end
    end

    always_comb begin
        if (aux_reg[EEPROM_STAT_BIT]) begin
            status_next = i_eeprom_status;
        end else begin
            status_next = i_status_src[sel];
        end
        if (auto_hold && aux_reg[LD_COMP_BIT]) begin
            hold_ind_next = cmp_sync;
        end else begin
            hold_ind_next = 1'b1;
        end
        // Monitor held low when the comparator is disabled or used by automatic holdover
        monitor_next   = ~auto_hold & aux_reg[LD_COMP_BIT] & cmp_sync;
        auto_hold_next = auto_hold;
    end

    // Register group: bus-visible state
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            aux_reg      <= AUX_RESET;
            stat_reg     <= STAT_RESET;
            pll_read_reg <= READ_RESET;
            rd_data_reg  <= '0;
        end else begin
            aux_reg      <= aux_next;
            stat_reg     <= stat_next;
            pll_read_reg <= pll_read_next;
            rd_data_reg  <= rd_data_next;
        end
    end

    // Pin group: registered so no pin glitches on a decode change
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            status_reg    <= 1'b0;
            hold_ind_reg  <= 1'b1;
            monitor_reg   <= 1'b0;
            auto_hold_reg <= 1'b0;
        end else begin
            status_reg    <= status_next;
            hold_ind_reg  <= hold_ind_next;
            monitor_reg   <= monitor_next;
            auto_hold_reg <= auto_hold_next;
        end
    end

    assign o_rd_data                    = rd_data_reg;
    assign o_status_pin                 = status_reg;
    assign o_crystal_maintaining_amp_en = aux_reg[XTAL_EN_BIT];
    assign o_doubler_en                 = aux_reg[DOUBLER_BIT];
    assign o_lock_detect_pin_cmp_en     = aux_reg[LD_COMP_BIT];
    assign o_holdover_lock_ind          = hold_ind_reg;
    assign o_ld_monitor                 = monitor_reg;
    assign o_auto_holdover              = auto_hold_reg;

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_reset);

    eeprom_override_a: assert property (
        aux_reg[EEPROM_STAT_BIT] |=> o_status_pin == $past(i_eeprom_status))
        else $error("status pin not stored-settings status");
    status_select_a: assert property (
        !aux_reg[EEPROM_STAT_BIT] |=> o_status_pin == $past(i_status_src[sel]))
        else $error("status pin not selected source");
    xtal_write_a: assert property (
        i_wr_en && i_addr == AUX_CTRL_ADDR |=>
        o_crystal_maintaining_amp_en == $past(i_wr_data[XTAL_EN_BIT]))
        else $error("amplifier enable not written");
    doubler_write_a: assert property (
        i_wr_en && i_addr == AUX_CTRL_ADDR |=>
        o_doubler_en == $past(i_wr_data[DOUBLER_BIT]))
        else $error("doubler enable not written");
    readback_freeze_a: assert property (
        aux_reg[FREEZE_BIT] |=> $stable(pll_read_reg))
        else $error("readback changed while frozen");
    readback_update_a: assert property (
        !aux_reg[FREEZE_BIT] |=> pll_read_reg == $past(i_pll_status))
        else $error("readback not updated");
    hold_cmp_use_a: assert property (
        auto_hold && aux_reg[LD_COMP_BIT] |=>
        o_holdover_lock_ind == $past(cmp_sync))
        else $error("holdover ignores comparator");
    hold_cmp_off_a: assert property (
        !aux_reg[LD_COMP_BIT] |=> o_holdover_lock_ind)
        else $error("lock indication not forced high");
    monitor_path_a: assert property (
        !auto_hold && aux_reg[LD_COMP_BIT] |=> o_ld_monitor == $past(cmp_sync))
        else $error("monitor not showing comparator");
    monitor_off_a: assert property (
        auto_hold || !aux_reg[LD_COMP_BIT] |=> !o_ld_monitor)
        else $error("monitor active while comparator unused");
    auto_hold_a: assert property (
        o_auto_holdover == $past(aux_reg[HOLD_EN_BIT] &
                                 ~aux_reg[EXT_HOLD_BIT]))
        else $error("automatic holdover flag wrong");
    hold_ext_a: assert property (
        aux_reg[EXT_HOLD_BIT] |=> !o_auto_holdover)
        else $error("holdover active under external control");

    // Write checks watch internal state so a slip shows at the write itself
    aux_write_a: assert property (
        i_wr_en && i_addr == AUX_CTRL_ADDR |=>
        aux_reg == $past(i_wr_data & AUX_USED_MASK))
        else $error("control register write lost");
    stat_write_a: assert property (
        i_wr_en && i_addr == STAT_CTRL_ADDR |=>
        stat_reg == $past(i_wr_data & STAT_USED_MASK))
        else $error("status control write lost");
    aux_read_a: assert property (
        i_rd_en && i_addr == AUX_CTRL_ADDR |=> o_rd_data == $past(aux_reg))
        else $error("control register read wrong");
    unmapped_read_a: assert property (
        i_rd_en && i_addr != AUX_CTRL_ADDR && i_addr != STAT_CTRL_ADDR &&
        i_addr != PLL_READ_ADDR |=> o_rd_data == '0)
        else $error("unmapped read not zero");
    rd_hold_a: assert property (
        !i_rd_en |=> $stable(o_rd_data))
        else $error("read data moved without a read");

    eeprom_clear_c: cover property (
        aux_reg[EEPROM_STAT_BIT] ##1 !aux_reg[EEPROM_STAT_BIT]);
    freeze_c: cover property (aux_reg[FREEZE_BIT] ##3 aux_reg[FREEZE_BIT]);
    hold_cmp_c: cover property (auto_hold && aux_reg[LD_COMP_BIT] && !cmp_sync);
    monitor_c: cover property (o_ld_monitor);
    ext_hold_c: cover property (aux_reg[HOLD_EN_BIT] && aux_reg[EXT_HOLD_BIT]);
endmodule : pac_aux_ctrl

// ===== tb/pll_aux_control_register_tb_top.sv
`timescale 1ns/10ps
module pll_aux_control_register_tb_top;
    import pac_pkg::*;
    logic i_clk, i_reset, i_wr_en, i_rd_en, i_eeprom_status;
    logic i_lock_detect_pin_cmp;
    logic [ADDR_W-1:0] i_addr;
    logic [DATA_W-1:0] i_wr_data, i_pll_status, o_rd_data, rd_val;
    logic [NUM_SRC-1:0] i_status_src;
    logic o_status_pin, o_crystal_maintaining_amp_en, o_doubler_en;
    logic o_lock_detect_pin_cmp_en, o_holdover_lock_ind, o_ld_monitor;
    logic o_auto_holdover;
    int fails = 0;
    int checks = 0;

    pac_aux_ctrl u_dut (.i_clk, .i_reset, .i_wr_en, .i_addr, .i_wr_data,
        .i_rd_en, .o_rd_data, .i_status_src, .i_eeprom_status,
        .i_pll_status, .i_lock_detect_pin_cmp, .o_status_pin,
        .o_crystal_maintaining_amp_en, .o_doubler_en,
        .o_lock_detect_pin_cmp_en, .o_holdover_lock_ind, .o_ld_monitor,
        .o_auto_holdover);

    initial begin
        i_clk = 1'b0;
        forever #2 i_clk = ~i_clk;
    end

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp) begin
            fails++;
            $display("wrong value at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask : chk

    // Sample 1 ns after the edge so that edge's updates have landed
    task automatic wt(input int n);
        repeat (n) @(posedge i_clk);
        #1;
    endtask : wt

    task automatic wr(input logic [9:0] a, input logic [7:0] d);
        @(posedge i_clk);
        i_wr_en <= 1'b1;
        i_addr <= a;
        i_wr_data <= d;
        @(posedge i_clk);
        i_wr_en <= 1'b0;
    endtask : wr

    task automatic rd(input logic [9:0] a);
        @(posedge i_clk);
        i_rd_en <= 1'b1;
        i_addr <= a;
        @(posedge i_clk);
        i_rd_en <= 1'b0;
        wt(1);
        rd_val = o_rd_data;
    endtask : rd

    task automatic conclude;
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : conclude

    task automatic test_reset;
        rd(AUX_CTRL_ADDR);
        chk(rd_val, 8'h80);
        chk(o_crystal_maintaining_amp_en, 1'b0);
        chk(o_doubler_en, 1'b0);
        chk(o_holdover_lock_ind, 1'b1);
        chk(o_auto_holdover, 1'b0);
        $display("test reset done");
    endtask : test_reset

    task automatic test_status;
        @(posedge i_clk);
        i_eeprom_status <= 1'b1;
        wt(3);
        chk(o_status_pin, 1'b1);
        @(posedge i_clk);
        i_eeprom_status <= 1'b0;
        wt(3);
        chk(o_status_pin, 1'b0);
        wr(STAT_CTRL_ADDR, 8'h14);
        wr(AUX_CTRL_ADDR, 8'h00);
        i_status_src <= 64'h20;
        wt(3);
        chk(o_status_pin, 1'b1);
        @(posedge i_clk);
        // Stored-settings status high must not leak through once overridden
        i_status_src <= ~64'h20;
        i_eeprom_status <= 1'b1;
        wt(3);
        chk(o_status_pin, 1'b0);
        $display("test status done");
    endtask : test_status

    task automatic test_enables;
        wr(AUX_CTRL_ADDR, 8'h6C);
        wt(2);
        chk(o_crystal_maintaining_amp_en, 1'b1);
        chk(o_doubler_en, 1'b1);
        chk(o_lock_detect_pin_cmp_en, 1'b1);
        rd(AUX_CTRL_ADDR);
        chk(rd_val, 8'h68);
        rd(10'h3FF);
        chk(rd_val, 8'h00);
        wr(STAT_CTRL_ADDR, 8'hFF);
        rd(STAT_CTRL_ADDR);
        chk(rd_val, 8'hFC);
        $display("test enables done");
    endtask : test_enables

    task automatic test_freeze;
        wr(AUX_CTRL_ADDR, 8'h00);
        i_pll_status <= 8'h5A;
        wt(3);
        rd(PLL_READ_ADDR);
        chk(rd_val, 8'h5A);
        wr(AUX_CTRL_ADDR, 8'h10);
        repeat (2) @(posedge i_clk);
        i_pll_status <= 8'hA5;
        wt(3);
        rd(PLL_READ_ADDR);
        chk(rd_val, 8'h5A);
        $display("test freeze done");
    endtask : test_freeze

    task automatic test_holdover;
        wr(AUX_CTRL_ADDR, 8'h09);
        i_lock_detect_pin_cmp <= 1'b0;
        wt(5);
        chk(o_auto_holdover, 1'b1);
        chk(o_holdover_lock_ind, 1'b0);
        @(posedge i_clk);
        i_lock_detect_pin_cmp <= 1'b1;
        wt(5);
        chk(o_holdover_lock_ind, 1'b1);
        @(posedge i_clk);
        i_lock_detect_pin_cmp <= 1'b0;
        wr(AUX_CTRL_ADDR, 8'h01);
        wt(5);
        chk(o_holdover_lock_ind, 1'b1);
        wr(AUX_CTRL_ADDR, 8'h08);
        wt(5);
        chk(o_auto_holdover, 1'b0);
        chk(o_ld_monitor, 1'b0);
        @(posedge i_clk);
        i_lock_detect_pin_cmp <= 1'b1;
        wt(5);
        chk(o_ld_monitor, 1'b1);
        // External holdover bit takes the automatic controller out of play
        wr(AUX_CTRL_ADDR, 8'h0B);
        wt(5);
        chk(o_auto_holdover, 1'b0);
        chk(o_ld_monitor, 1'b1);
        $display("test holdover done");
    endtask : test_holdover

    initial begin
        {i_wr_en, i_rd_en, i_eeprom_status, i_lock_detect_pin_cmp} = 4'h0;
        i_addr = 10'h000;
        i_wr_data = 8'h00;
        i_pll_status = 8'h00;
        i_status_src = 64'h0;
        i_reset = 1'b1;
        repeat (5) @(posedge i_clk);
        i_reset <= 1'b0;
        test_reset();
        test_status();
        test_enables();
        test_freeze();
        test_holdover();
        conclude();
    end

    // Tests need about a hundred cycles; 5000 leaves ample margin
    initial begin
        #20000;
        fails++;
        conclude();
    end
endmodule : pll_aux_control_register_tb_top
